// ===== verilog/secondary_cache_pkg.sv
// Constants, field layouts and state codes for the second-level cache block.
// Assumes a 40-bit physical address and one processor clock for all users.
package secondary_cache_pkg;
	localparam int PA_W = 40;
	localparam int PA_MSB = PA_W - 1;
	localparam int TAG_W = 23;
	localparam int TAG_LSB = 17;
	localparam int IDX_MSB = 16;
	localparam int IDX_LSB = 5;
	localparam int IDX_W = IDX_MSB - IDX_LSB + 1;
	localparam int DW_MSB = 4;
	localparam int DW_LSB = 3;
	localparam int BYTE_MSB = 2;
	localparam int WAYS = 4;
	localparam int WAY_W = 2;
	localparam int SETS = 4096;
	localparam int LINE_W = 256;
	localparam int DW_W = 64;
	localparam int BE_W = 8;
	localparam int BYTE_W = 8;
	localparam int ENTRY_W = LINE_W + TAG_W + 2;
	localparam int VALID_BIT = ENTRY_W - 1;
	localparam int DIRTY_BIT = ENTRY_W - 2;
	localparam int TAG_MSB_E = LINE_W + TAG_W - 1;
	localparam logic [IDX_W-1:0] LAST_SET = 12'hfff;
	localparam logic [IDX_LSB-1:0] LINE_OFS0 = 5'h00;
	localparam logic [BYTE_MSB:0] BYTE_OFS0 = 3'h0;
	localparam logic [2:0] ATTR_UC = 3'h2;
	localparam logic [2:0] ATTR_WB = 3'h3;
	localparam logic [2:0] ATTR_UCA = 3'h7;
	localparam logic [1:0] KIND_LOAD = 2'h0;
	localparam logic [1:0] KIND_STORE = 2'h1;
	localparam logic [1:0] KIND_IFETCH = 2'h2;
	localparam logic [1:0] KIND_WRBACK = 2'h3;
	localparam logic [1:0] CMD_SRD = 2'h0;
	localparam logic [1:0] CMD_SWR = 2'h1;
	localparam logic [1:0] CMD_BRD = 2'h2;
	localparam logic [1:0] CMD_BWR = 2'h3;
	localparam logic [WAYS-1:0] ALL_WAYS = 4'hf;
	localparam logic [2:0] DW_PER_LINE = 3'h4;
	localparam logic [BE_W-1:0] FULL_BE = 8'hff;
	localparam logic [15:0] LFSR_SEED = 16'hace1;
	localparam logic [15:0] LFSR_TAPS = 16'hb400;
	typedef enum logic [10:0] {
		ST_INIT = 11'h001,
		ST_IDLE = 11'h002,
		ST_DECIDE = 11'h004,
		ST_LOOKUP = 11'h008,
		ST_COMPARE = 11'h010,
		ST_CMD = 11'h020,
		ST_RDWAIT = 11'h040,
		ST_FETCH = 11'h080,
		ST_INSTALL = 11'h100,
		ST_DRAIN = 11'h200,
		ST_GBLK = 11'h400
	} fsm_t;
endpackage

// ===== verilog/line_store.sv
// One way of the second-level array: tag, state bits and line per set.
// Assumes one shared address for read and write; read data is registered.
`timescale 1ns/100ps
`default_nettype none
module line_store (
	input wire logic sys_clk,
	input wire logic wrEn,
	input wire logic [secondary_cache_pkg::IDX_W-1:0] addr,
	input wire logic [secondary_cache_pkg::ENTRY_W-1:0] wrData,
	output logic [secondary_cache_pkg::ENTRY_W-1:0] rdData
);
	logic [secondary_cache_pkg::ENTRY_W-1:0] mem [secondary_cache_pkg::SETS];

	// Contents are unknown after power-up, so the owner sweeps every set.
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[addr] <= wrData;
		end
		rdData <= mem[addr];
	end
endmodule // line_store
`default_nettype wire

// ===== verilog/secondary_cache_coherency.sv
// Second-level cache controller with attribute-driven memory access paths.
// Assumes primary caches above and a command/read-data memory bus below.
`timescale 1ns/100ps
`default_nettype none
// Contract
// (RULE1) Unified four-way write-back cache, 512 KB, 32-byte lines.
// (RULE2) Each line holds 32 data bytes, a 23-bit tag, two state bits.
// (RULE3) Lookup begins only after the primary cache reports a tag miss.
// (RULE4) Physical index and tag; address bits 16:5 select the set.
// (RULE5) Bits 4:3 pick the doubleword, bits 2:0 the byte.
// (RULE6) Software keeps shared memory consistent; no hardware snooping exists.
// (RULE7) Three-bit page attribute: 2 uncached, 3 write-back, 7 gathering.
// (RULE8) Uncached loads stall until done; uncached stores go first.
// (RULE9) Uncached accesses bypass caches as single sized memory requests.
// (RULE10) Unmapped uncached segment accesses always use the uncached attribute.
// (RULE11) Write-back store hits touch only the primary cache.
// (RULE12) Second level changes only by fills and writebacks; memory by blocks.
// (RULE13) Primary miss fills from second level, else block read fills both.
// (RULE14) Write-back traffic may run ahead of and out of program order.
// (RULE15) Gathering stores collect into a line buffer; full buffer writes block.
// (RULE16) An interrupting uncached store drains the buffer as single stores.
// (RULE17) Barrier holds until stores reached the bus and loads completed.
// (RULE18) Match invalidate and flush operations pipeline; misses cause no stall.
// (RULE19) Clean match hit costs only the tag invalidate cycle.
// (RULE20) Victim way is chosen randomly.
// (RULE21) After reset all lines are invalid until filled.
module secondary_cache_coherency (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reqValid,
	input wire logic reqL1Miss,
	input wire logic [1:0] reqKind,
	input wire logic [2:0] reqAttr,
	input wire logic reqUnmappedUncached,
	input wire logic [secondary_cache_pkg::PA_W-1:0] reqAddr,
	input wire logic [secondary_cache_pkg::DW_W-1:0] reqData,
	input wire logic [secondary_cache_pkg::BE_W-1:0] reqByteEn,
	input wire logic [3:0] reqSize,
	input wire logic [secondary_cache_pkg::LINE_W-1:0] reqLine,
	output logic reqReady,
	output logic respValid,
	output logic [secondary_cache_pkg::LINE_W-1:0] respLine,
	output logic memCmdValid,
	input wire logic memCmdReady,
	output logic [1:0] memCmdKind,
	output logic [2:0] memCmdAttr,
	output logic [secondary_cache_pkg::PA_W-1:0] memAddr,
	output logic [secondary_cache_pkg::BE_W-1:0] memByteEn,
	output logic [secondary_cache_pkg::LINE_W-1:0] memWdata,
	input wire logic memRdValid,
	input wire logic [secondary_cache_pkg::LINE_W-1:0] memRdData,
	input wire logic syncReq,
	input wire logic [4:0] pendingLoads,
	output logic syncHold,
	input wire logic mopValid,
	input wire logic mopFlush,
	input wire logic l1MatchHit,
	input wire logic l1MatchDirty,
	output logic l1Invalidate,
	output logic l1WritebackReq,
	output logic mopStall
);
	typedef struct packed {
		secondary_cache_pkg::fsm_t fsm;
		secondary_cache_pkg::fsm_t after;
		logic [secondary_cache_pkg::IDX_W-1:0] idx;
		logic [secondary_cache_pkg::WAY_W-1:0] way;
		logic [secondary_cache_pkg::WAYS-1:0] wrEn;
		logic [secondary_cache_pkg::ENTRY_W-1:0] wrEntry;
		logic held;
		logic [1:0] kind;
		logic [2:0] attr;
		logic [secondary_cache_pkg::PA_W-1:0] addr;
		logic [secondary_cache_pkg::DW_W-1:0] data;
		logic [secondary_cache_pkg::BE_W-1:0] byteEn;
		logic [3:0] size;
		logic [secondary_cache_pkg::LINE_W-1:0] line;
		logic gActive;
		logic [secondary_cache_pkg::LINE_W-1:0] gData;
		logic [secondary_cache_pkg::LINE_W/8-1:0] gMask;
		logic [secondary_cache_pkg::PA_W-1:0] gNext;
		logic [secondary_cache_pkg::PA_MSB-secondary_cache_pkg::IDX_LSB:0] gBase;
		logic [3:0] gSize;
		logic [2:0] gPtr;
		logic [15:0] lfsr;
		logic reqReady;
		logic respValid;
		logic [secondary_cache_pkg::LINE_W-1:0] respLine;
		logic memCmdValid;
		logic [1:0] memCmdKind;
		logic [2:0] memCmdAttr;
		logic [secondary_cache_pkg::PA_W-1:0] memAddr;
		logic [secondary_cache_pkg::BE_W-1:0] memByteEn;
		logic [secondary_cache_pkg::LINE_W-1:0] memWdata;
		logic syncHold;
		logic l1Invalidate;
		logic l1WritebackReq;
		logic mopStall;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic [secondary_cache_pkg::ENTRY_W-1:0] rdEntry [secondary_cache_pkg::WAYS];
	logic [secondary_cache_pkg::WAYS-1:0] hitVec;
	logic [2:0] attrEff;
	logic fillKind;
	logic accept;

	function automatic logic [secondary_cache_pkg::TAG_W-1:0] tagOf(
		input logic [secondary_cache_pkg::PA_W-1:0] a);
		tagOf = a[secondary_cache_pkg::PA_MSB:secondary_cache_pkg::TAG_LSB];
	endfunction

	function automatic logic [secondary_cache_pkg::IDX_W-1:0] idxOf(
		input logic [secondary_cache_pkg::PA_W-1:0] a);
		idxOf = a[secondary_cache_pkg::IDX_MSB:secondary_cache_pkg::IDX_LSB];
	endfunction

	// (RULE1) Four ways of the unified array.
	// (RULE2) Each entry is valid, dirty, tag and line.
	generate
		for (genvar w = 0; w < secondary_cache_pkg::WAYS; w++) begin : g_way
			line_store u_way (
				.sys_clk(sys_clk),
				.wrEn(s_reg.wrEn[w]),
				.addr(s_reg.idx),
				.wrData(s_reg.wrEntry),
				.rdData(rdEntry[w])
			);
			// (RULE4) Physical tag compare.
			assign hitVec[w] = rdEntry[w][secondary_cache_pkg::VALID_BIT] &&
				rdEntry[w][secondary_cache_pkg::TAG_MSB_E:
				secondary_cache_pkg::LINE_W] == tagOf(s_reg.addr);
		end
	endgenerate

	// (RULE10) Unmapped uncached segment forces blocking uncached.
	// (RULE7) Reserved codes are also handled as blocking uncached.
	always_comb begin
		if (reqUnmappedUncached) begin
			attrEff = secondary_cache_pkg::ATTR_UC;
		end else if (reqAttr == secondary_cache_pkg::ATTR_WB ||
			reqAttr == secondary_cache_pkg::ATTR_UCA) begin
			attrEff = reqAttr;
		end else begin
			attrEff = secondary_cache_pkg::ATTR_UC;
		end
	end

	assign fillKind = reqKind != secondary_cache_pkg::KIND_WRBACK;
	// (RULE3) Cached fills are taken only with the primary miss flag.
	assign accept = reqValid && s_reg.reqReady &&
		!(syncReq && s_reg.gActive) &&
		(!fillKind || attrEff != secondary_cache_pkg::ATTR_WB || reqL1Miss);

	always_comb begin
		logic [secondary_cache_pkg::ENTRY_W-1:0] vic;
		logic [secondary_cache_pkg::BE_W-1:0] dwMask;
		logic [1:0] dw;
		vic = '0;
		dwMask = '0;
		dw = '0;
		s_next = s_reg;
		s_next.respValid = 1'b0;
		s_next.wrEn = '0;
		// (RULE20) Free-running pseudo-random source for victim ways.
		s_next.lfsr = {s_reg.lfsr[14:0],
			^(s_reg.lfsr & secondary_cache_pkg::LFSR_TAPS)};
		case (s_reg.fsm)
			secondary_cache_pkg::ST_INIT: begin
				// (RULE21) Sweep writes invalid entries into every set.
				s_next.wrEn = secondary_cache_pkg::ALL_WAYS;
				s_next.idx = s_reg.idx + 12'h001;
				if (s_reg.idx == secondary_cache_pkg::LAST_SET) begin
					s_next.wrEn = '0;
					s_next.fsm = secondary_cache_pkg::ST_IDLE;
				end
			end
			secondary_cache_pkg::ST_IDLE: begin
				if (syncReq && s_reg.gActive) begin
					s_next.gPtr = '0;
					s_next.fsm = secondary_cache_pkg::ST_DRAIN;
				end else if (accept) begin
					s_next.held = 1'b1;
					s_next.kind = reqKind;
					s_next.attr = attrEff;
					s_next.addr = reqAddr;
					s_next.data = reqData;
					s_next.byteEn = reqByteEn;
					s_next.size = reqSize;
					s_next.line = reqLine;
					s_next.idx = idxOf(reqAddr);
					s_next.fsm = secondary_cache_pkg::ST_DECIDE;
				end
			end
			secondary_cache_pkg::ST_DECIDE: begin
				s_next.memCmdAttr = s_reg.attr;
				s_next.memAddr = s_reg.addr;
				s_next.memByteEn = s_reg.byteEn;
				s_next.memWdata = {{(secondary_cache_pkg::LINE_W -
					secondary_cache_pkg::DW_W){1'b0}}, s_reg.data};
				// (RULE11) Only primary misses, evictions and uncached accesses reach here.
				if (s_reg.kind == secondary_cache_pkg::KIND_WRBACK ||
					s_reg.attr == secondary_cache_pkg::ATTR_WB) begin
					// (RULE14) Write-back traffic keeps no program order.
					s_next.fsm = secondary_cache_pkg::ST_LOOKUP;
				end else if (s_reg.kind != secondary_cache_pkg::KIND_STORE) begin
					// (RULE8) Uncached loads stall until read data returns.
					s_next.memCmdValid = 1'b1;
					s_next.memCmdKind = secondary_cache_pkg::CMD_SRD;
					s_next.after = secondary_cache_pkg::ST_RDWAIT;
					s_next.fsm = secondary_cache_pkg::ST_CMD;
				end else if (s_reg.gActive &&
					(s_reg.attr != secondary_cache_pkg::ATTR_UCA ||
					s_reg.addr != s_reg.gNext || s_reg.size != s_reg.gSize ||
					s_reg.addr[secondary_cache_pkg::PA_MSB:
					secondary_cache_pkg::IDX_LSB] != s_reg.gBase)) begin
					// (RULE16) A foreign store breaks the gathering run.
					s_next.gPtr = '0;
					s_next.fsm = secondary_cache_pkg::ST_DRAIN;
				end else if (s_reg.attr == secondary_cache_pkg::ATTR_UCA) begin
					// (RULE15) Merge the store into the line buffer.
					// (RULE5) Bits 4:3 pick the doubleword lane.
					dw = s_reg.addr[secondary_cache_pkg::DW_MSB:
						secondary_cache_pkg::DW_LSB];
					for (int b = 0; b < secondary_cache_pkg::BE_W; b++) begin
						if (s_reg.byteEn[b]) begin
							s_next.gData[(int'(dw) * secondary_cache_pkg::BE_W + b) *
								secondary_cache_pkg::BYTE_W +: secondary_cache_pkg::BYTE_W] =
								s_reg.data[b * secondary_cache_pkg::BYTE_W +:
								secondary_cache_pkg::BYTE_W];
							s_next.gMask[int'(dw) * secondary_cache_pkg::BE_W + b] = 1'b1;
						end
					end
					if (!s_reg.gActive) begin
						s_next.gBase = s_reg.addr[secondary_cache_pkg::PA_MSB:
							secondary_cache_pkg::IDX_LSB];
						s_next.gSize = s_reg.size;
					end
					s_next.gActive = 1'b1;
					s_next.gNext = s_reg.addr +
						{{(secondary_cache_pkg::PA_W - 4){1'b0}}, s_reg.size};
					s_next.respValid = 1'b1;
					s_next.fsm = (&s_next.gMask) ? secondary_cache_pkg::ST_GBLK :
						secondary_cache_pkg::ST_IDLE;
				end else begin
					// (RULE9) Blocking uncached store goes out as one sized write.
					s_next.memCmdValid = 1'b1;
					s_next.memCmdKind = secondary_cache_pkg::CMD_SWR;
					s_next.after = secondary_cache_pkg::ST_IDLE;
					s_next.respValid = 1'b1;
					s_next.fsm = secondary_cache_pkg::ST_CMD;
				end
			end
			secondary_cache_pkg::ST_LOOKUP: begin
				s_next.fsm = secondary_cache_pkg::ST_COMPARE;
			end
			secondary_cache_pkg::ST_COMPARE: begin
				if (|hitVec) begin
					for (int i = secondary_cache_pkg::WAYS - 1; i >= 0; i--) begin
						if (hitVec[i]) begin
							s_next.way = i[secondary_cache_pkg::WAY_W-1:0];
						end
					end
					s_next.respValid = 1'b1;
					s_next.respLine = rdEntry[s_next.way][secondary_cache_pkg::LINE_W-1:0];
					// (RULE12) A block writeback replaces the whole line.
					if (s_reg.kind == secondary_cache_pkg::KIND_WRBACK) begin
						s_next.wrEn[s_next.way] = 1'b1;
						s_next.wrEntry = {2'b11, tagOf(s_reg.addr), s_reg.line};
					end
					s_next.fsm = secondary_cache_pkg::ST_IDLE;
				end else begin
					// (RULE20) Random victim way on a miss.
					s_next.way = s_reg.lfsr[secondary_cache_pkg::WAY_W-1:0];
					vic = rdEntry[s_next.way];
					s_next.after = (s_reg.kind == secondary_cache_pkg::KIND_WRBACK) ?
						secondary_cache_pkg::ST_INSTALL : secondary_cache_pkg::ST_FETCH;
					s_next.fsm = s_next.after;
					if (vic[secondary_cache_pkg::VALID_BIT] &&
						vic[secondary_cache_pkg::DIRTY_BIT]) begin
						// (RULE12) Dirty victim leaves as a block write.
						s_next.memCmdValid = 1'b1;
						s_next.memCmdKind = secondary_cache_pkg::CMD_BWR;
						s_next.memCmdAttr = secondary_cache_pkg::ATTR_WB;
						s_next.memAddr = {vic[secondary_cache_pkg::TAG_MSB_E:
							secondary_cache_pkg::LINE_W], s_reg.idx,
							secondary_cache_pkg::LINE_OFS0};
						s_next.memByteEn = secondary_cache_pkg::FULL_BE;
						s_next.memWdata = vic[secondary_cache_pkg::LINE_W-1:0];
						s_next.fsm = secondary_cache_pkg::ST_CMD;
					end
				end
			end
			secondary_cache_pkg::ST_FETCH: begin
				// (RULE13) Second-level miss fetches the line from memory.
				s_next.memCmdValid = 1'b1;
				s_next.memCmdKind = secondary_cache_pkg::CMD_BRD;
				s_next.memCmdAttr = secondary_cache_pkg::ATTR_WB;
				s_next.memAddr = {s_reg.addr[secondary_cache_pkg::PA_MSB:
					secondary_cache_pkg::IDX_LSB], secondary_cache_pkg::LINE_OFS0};
				s_next.memByteEn = secondary_cache_pkg::FULL_BE;
				s_next.after = secondary_cache_pkg::ST_RDWAIT;
				s_next.fsm = secondary_cache_pkg::ST_CMD;
			end
			secondary_cache_pkg::ST_CMD: begin
				if (memCmdReady) begin
					s_next.memCmdValid = 1'b0;
					s_next.fsm = s_reg.after;
				end
			end
			secondary_cache_pkg::ST_RDWAIT: begin
				if (memRdValid) begin
					if (s_reg.attr == secondary_cache_pkg::ATTR_WB) begin
						s_next.line = memRdData;
						s_next.fsm = secondary_cache_pkg::ST_INSTALL;
					end else begin
						s_next.respLine = memRdData;
						s_next.respValid = 1'b1;
						s_next.fsm = secondary_cache_pkg::ST_IDLE;
					end
				end
			end
			secondary_cache_pkg::ST_INSTALL: begin
				// (RULE13) Fill both levels with the same line.
				s_next.wrEn[s_reg.way] = 1'b1;
				s_next.wrEntry = {1'b1, s_reg.kind == secondary_cache_pkg::KIND_WRBACK,
					tagOf(s_reg.addr), s_reg.line};
				s_next.respLine = s_reg.line;
				s_next.respValid = 1'b1;
				s_next.fsm = secondary_cache_pkg::ST_IDLE;
			end
			secondary_cache_pkg::ST_DRAIN: begin
				if (s_reg.gPtr == secondary_cache_pkg::DW_PER_LINE) begin
					s_next.gActive = 1'b0;
					s_next.gMask = '0;
					s_next.fsm = s_reg.held ? secondary_cache_pkg::ST_DECIDE :
						secondary_cache_pkg::ST_IDLE;
				end else begin
					dwMask = s_reg.gMask[s_reg.gPtr[1:0] * secondary_cache_pkg::BE_W +:
						secondary_cache_pkg::BE_W];
					s_next.gPtr = s_reg.gPtr + 3'h1;
					if (|dwMask) begin
						// (RULE16) Each buffered doubleword becomes a single store.
						s_next.memCmdValid = 1'b1;
						s_next.memCmdKind = secondary_cache_pkg::CMD_SWR;
						s_next.memCmdAttr = secondary_cache_pkg::ATTR_UCA;
						s_next.memAddr = {s_reg.gBase, s_reg.gPtr[1:0],
							secondary_cache_pkg::BYTE_OFS0};
						s_next.memByteEn = dwMask;
						s_next.memWdata = {{(secondary_cache_pkg::LINE_W -
							secondary_cache_pkg::DW_W){1'b0}},
							s_reg.gData[s_reg.gPtr[1:0] * secondary_cache_pkg::DW_W +:
							secondary_cache_pkg::DW_W]};
						s_next.after = secondary_cache_pkg::ST_DRAIN;
						s_next.fsm = secondary_cache_pkg::ST_CMD;
					end
				end
			end
			secondary_cache_pkg::ST_GBLK: begin
				// (RULE15) A full buffer leaves as one block write.
				s_next.memCmdValid = 1'b1;
				s_next.memCmdKind = secondary_cache_pkg::CMD_BWR;
				s_next.memCmdAttr = secondary_cache_pkg::ATTR_UCA;
				s_next.memAddr = {s_reg.gBase, secondary_cache_pkg::LINE_OFS0};
				s_next.memByteEn = secondary_cache_pkg::FULL_BE;
				s_next.memWdata = s_reg.gData;
				s_next.gActive = 1'b0;
				s_next.gMask = '0;
				s_next.after = secondary_cache_pkg::ST_IDLE;
				s_next.fsm = secondary_cache_pkg::ST_CMD;
			end
			default: begin
				s_next.fsm = secondary_cache_pkg::ST_IDLE;
			end
		endcase
		if (s_next.fsm == secondary_cache_pkg::ST_IDLE) begin
			s_next.held = 1'b0;
		end
		// (RULE8) Nothing new is taken while a blocking access is in flight.
		s_next.reqReady = s_next.fsm == secondary_cache_pkg::ST_IDLE;
		// (RULE17) Barrier waits for idle bus path, empty buffer, no loads.
		s_next.syncHold = syncReq && (s_next.fsm != secondary_cache_pkg::ST_IDLE ||
			s_next.gActive || pendingLoads != 5'h00);
		// (RULE18) Match operations never stall on a miss.
		// (RULE19) A hit costs the single invalidate cycle.
		s_next.l1Invalidate = mopValid && l1MatchHit;
		s_next.mopStall = mopValid && l1MatchHit;
		s_next.l1WritebackReq = mopValid && l1MatchHit && l1MatchDirty && mopFlush;
	end

	// The sweep costs one cycle per set after reset; lookups wait for it.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.fsm <= secondary_cache_pkg::ST_INIT;
			s_reg.after <= secondary_cache_pkg::ST_IDLE;
			s_reg.wrEn <= secondary_cache_pkg::ALL_WAYS;
			s_reg.lfsr <= secondary_cache_pkg::LFSR_SEED;
		end else begin
			s_reg <= s_next;
		end
	end

	assign reqReady = s_reg.reqReady;
	assign respValid = s_reg.respValid;
	assign respLine = s_reg.respLine;
	assign memCmdValid = s_reg.memCmdValid;
	assign memCmdKind = s_reg.memCmdKind;
	assign memCmdAttr = s_reg.memCmdAttr;
	assign memAddr = s_reg.memAddr;
	assign memByteEn = s_reg.memByteEn;
	assign memWdata = s_reg.memWdata;
	assign syncHold = s_reg.syncHold;
	assign l1Invalidate = s_reg.l1Invalidate;
	assign l1WritebackReq = s_reg.l1WritebackReq;
	assign mopStall = s_reg.mopStall;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	init_invalid_a: assert property ( // RULE21
		s_reg.fsm == secondary_cache_pkg::ST_INIT |-> s_reg.wrEn ==
		secondary_cache_pkg::ALL_WAYS && !s_reg.wrEntry[secondary_cache_pkg::VALID_BIT])
		else $error("Init sweep not writing invalid entries.");
	miss_gate_a: assert property ( // RULE3
		s_reg.fsm == secondary_cache_pkg::ST_IDLE && reqValid && reqReady &&
		fillKind && attrEff == secondary_cache_pkg::ATTR_WB && !reqL1Miss
		|=> !s_reg.held)
		else $error("Lookup started without primary miss.");
	uc_bypass_a: assert property ( // RULE9
		s_reg.fsm == secondary_cache_pkg::ST_DECIDE &&
		s_reg.attr == secondary_cache_pkg::ATTR_UC &&
		s_reg.kind == secondary_cache_pkg::KIND_LOAD
		|=> memCmdValid && memCmdKind == secondary_cache_pkg::CMD_SRD)
		else $error("Uncached load not issued as single read.");
	uc_stall_a: assert property ( // RULE8
		memCmdValid && memCmdKind == secondary_cache_pkg::CMD_SRD
		|-> !reqReady throughout (!respValid [*1]))
		else $error("Request taken during blocking read.");
	l2_write_a: assert property ( // RULE12
		(|s_reg.wrEn) && s_reg.fsm != secondary_cache_pkg::ST_INIT
		|-> $past(s_reg.fsm) == secondary_cache_pkg::ST_INSTALL ||
		($past(s_reg.fsm) == secondary_cache_pkg::ST_COMPARE &&
		s_reg.kind == secondary_cache_pkg::KIND_WRBACK))
		else $error("Second level written outside fill or writeback.");
	gather_block_a: assert property ( // RULE15
		s_reg.fsm == secondary_cache_pkg::ST_GBLK |=> memCmdValid &&
		memCmdKind == secondary_cache_pkg::CMD_BWR && !s_reg.gActive)
		else $error("Full gather buffer not written as block.");
	drain_single_a: assert property ( // RULE16
		s_reg.fsm == secondary_cache_pkg::ST_DRAIN && s_reg.gPtr !=
		secondary_cache_pkg::DW_PER_LINE ##1 memCmdValid
		|-> memCmdKind == secondary_cache_pkg::CMD_SWR)
		else $error("Drain used a non-single write.");
	sync_hold_a: assert property ( // RULE17
		syncReq && pendingLoads != 5'h00 |=> syncHold)
		else $error("Barrier released with loads pending.");
	mop_miss_a: assert property ( // RULE18
		mopValid && !l1MatchHit |=> !mopStall && !l1Invalidate)
		else $error("Match miss caused a stall.");
	mop_clean_a: assert property ( // RULE19
		mopValid && l1MatchHit && !l1MatchDirty ##1 !mopValid
		|-> mopStall && l1Invalidate ##1 !mopStall)
		else $error("Clean match hit stalled longer than one cycle.");

	hit_fill_c: cover property (
		s_reg.fsm == secondary_cache_pkg::ST_COMPARE && (|hitVec));
	evict_fill_c: cover property (
		s_reg.fsm == secondary_cache_pkg::ST_INSTALL && s_reg.kind ==
		secondary_cache_pkg::KIND_LOAD);
	gather_full_c: cover property (s_reg.fsm == secondary_cache_pkg::ST_GBLK);
	drain_c: cover property (
		s_reg.fsm == secondary_cache_pkg::ST_DRAIN && s_reg.held);
endmodule // secondary_cache_coherency
`default_nettype wire

// ===== sim/mem_partner.sv
// Memory model on the far side of the block's memory command port.
// Assumes one command outstanding; reads return an address pattern.
`timescale 1ns/100ps
`default_nettype none
module mem_partner (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic memCmdValid,
	input wire logic [1:0] memCmdKind,
	input wire logic [39:0] memAddr,
	output logic memCmdReady,
	output logic memRdValid,
	output logic [255:0] memRdData
);
	// memory never snoops.
	// Idle read data toggles so a stale bus never looks like a match.
	always_ff @(posedge sys_clk) begin
		memCmdReady <= memCmdValid & ~memCmdReady & ~rst;
		memRdValid <= memCmdValid & memCmdReady & ~memCmdKind[0] & ~rst;
		if (rst)
			memRdData <= 256'h0;
		else if (memCmdValid & memCmdReady)
			memRdData <= {8{memAddr[31:0]}};
		else
			memRdData <= ~memRdData;
	end
endmodule // mem_partner
`default_nettype wire

// ===== sim/secondary_cache_coherency_bench.sv
// Bench for the cache: fills, hits, uncached paths, maintenance, barrier.
// Assumes the memory partner model answers every command promptly.
`timescale 1ns/100ps
`default_nettype none
module secondary_cache_coherency_bench;
	logic sys_clk = 0, rst = 1, reqValid = 0, reqL1Miss = 1, reqUnm = 0;
	logic mopValid = 0, mopFlush = 0, hit = 0, dirty = 0, syncReq = 0;
	logic [1:0] reqKind = 0, memCmdKind, lastKind;
	logic [2:0] reqAttr = 0, memCmdAttr;
	logic [39:0] reqAddr = 0, memAddr;
	logic [63:0] reqData = 0;
	logic [255:0] respLine, memWdata, memRdData;
	logic [7:0] memByteEn;
	logic [4:0] pendingLoads = 0;
	logic reqReady, respValid, memCmdValid, memCmdReady, memRdValid;
	logic syncHold, l1Invalidate, l1WritebackReq, mopStall;
	int nErrors = 0, checksDone = 0, nCmd = 0, lat;
	secondary_cache_coherency DUT (.sys_clk(sys_clk), .rst(rst),
		.reqValid(reqValid), .reqL1Miss(reqL1Miss), .reqKind(reqKind),
		.reqAttr(reqAttr), .reqUnmappedUncached(reqUnm), .reqAddr(reqAddr),
		.reqData(reqData), .reqByteEn(8'h0), .reqSize(4'h0), .reqLine(256'h0),
		.reqReady(reqReady), .respValid(respValid), .respLine(respLine),
		.memCmdValid(memCmdValid), .memCmdReady(memCmdReady),
		.memCmdKind(memCmdKind), .memCmdAttr(memCmdAttr), .memAddr(memAddr),
		.memByteEn(memByteEn), .memWdata(memWdata), .memRdValid(memRdValid),
		.memRdData(memRdData), .syncReq(syncReq), .pendingLoads(pendingLoads),
		.syncHold(syncHold), .mopValid(mopValid), .mopFlush(mopFlush),
		.l1MatchHit(hit), .l1MatchDirty(dirty), .l1Invalidate(l1Invalidate),
		.l1WritebackReq(l1WritebackReq), .mopStall(mopStall));
	mem_partner mem (.sys_clk(sys_clk), .rst(rst), .memCmdValid(memCmdValid),
		.memCmdKind(memCmdKind), .memAddr(memAddr), .memCmdReady(memCmdReady),
		.memRdValid(memRdValid), .memRdData(memRdData));
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (memCmdValid && memCmdReady) begin
		nCmd <= nCmd + 1;
		lastKind <= memCmdKind;
	end
	task chk(input logic ok, input string m);
		checksDone++;
		if (ok !== 1'b1) begin
			nErrors++;
			$display("CHECK FAILED at %0t: %s", $time, m);
		end
	endtask
	// The request waits for reqReady first, is raised at the next edge and is taken at the edge after that.
	task automatic req(input logic [1:0] k, input logic [2:0] a,
		input logic u, input logic [39:0] ad);
		int i;
		for (i = 0; i < 6000 && reqReady !== 1'b1; i++) @(negedge sys_clk);
		chk(i < 6000, "ready timeout");
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqAttr <= a;
		reqUnm <= u;
		reqAddr <= ad;
		reqData <= {24'h0, ad};
		@(posedge sys_clk);
		reqValid <= 1'b0;
		for (lat = 1; lat < 2000; lat++) begin
			@(posedge sys_clk);
			@(negedge sys_clk);
			if (respValid === 1'b1) break;
		end
		chk(lat < 2000, "response timeout");
	endtask
	// A write-back request without the primary miss flag must be ignored.
	task automatic gate;
		@(posedge sys_clk);
		reqL1Miss <= 1'b0;
		reqUnm <= 1'b0;
		reqAttr <= secondary_cache_pkg::ATTR_WB;
		reqValid <= 1'b1;
		for (int k = 0; k < 6; k++) begin
			@(negedge sys_clk);
			chk(reqReady === 1'b1 && respValid === 1'b0, "miss gate");
		end
		@(posedge sys_clk);
		reqValid <= 1'b0;
		reqL1Miss <= 1'b1;
	endtask
	task automatic mop(input logic h, input logic d, input logic f);
		@(posedge sys_clk);
		mopValid <= 1'b1;
		hit <= h;
		dirty <= d;
		mopFlush <= f;
		@(posedge sys_clk);
		mopValid <= 1'b0;
		@(negedge sys_clk);
		chk(l1Invalidate === h && mopStall === h &&
			l1WritebackReq === (h & d & f), "maintenance pulse");
	endtask
	task completeRun;
		$display("errors %0d checks %0d", nErrors, checksDone);
		if (nErrors == 0 && checksDone > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		nErrors++;
		completeRun;
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		req(2'h0, 3'h3, 1'b0, 40'h12_3456_7848);
		chk(nCmd === 1 && lastKind === secondary_cache_pkg::CMD_BRD &&
			memAddr === 40'h12_3456_7840 && memByteEn === 8'hff &&
			respLine === {8{32'h3456_7840}}, "line fill");
		req(2'h2, 3'h3, 1'b0, 40'h12_3456_7848);
		chk(lat === 3 && nCmd === 1 &&
			respLine === {8{32'h3456_7840}}, "unified hit");
		req(2'h0, 3'h3, 1'b0, 40'h13_3456_7848);
		chk(nCmd === 2, "tag miss");
		req(2'h0, 3'h2, 1'b0, 40'h12_3456_7848);
		chk(nCmd === 3 && lastKind === secondary_cache_pkg::CMD_SRD &&
			memAddr === 40'h12_3456_7848, "uncached bypass");
		req(2'h0, 3'h3, 1'b1, 40'h12_3456_7848);
		chk(nCmd === 4 && lastKind === secondary_cache_pkg::CMD_SRD &&
			memCmdAttr === 3'h2, "segment uncached");
		req(2'h1, 3'h2, 1'b0, 40'h12_3456_7850);
		repeat (3) @(negedge sys_clk);
		chk(nCmd === 5 && lastKind === secondary_cache_pkg::CMD_SWR &&
			memWdata === {216'h0, 40'h12_3456_7850}, "uncached store");
		gate;
		mop(1'b1, 1'b0, 1'b0);
		mop(1'b0, 1'b1, 1'b1);
		mop(1'b1, 1'b1, 1'b1);
		@(posedge sys_clk);
		syncReq <= 1'b1;
		pendingLoads <= 5'h03;
		repeat (3) @(negedge sys_clk);
		chk(syncHold === 1'b1, "barrier held");
		@(posedge sys_clk);
		pendingLoads <= 5'h00;
		repeat (3) @(negedge sys_clk);
		chk(syncHold === 1'b0, "barrier freed");
		completeRun;
	end
endmodule // secondary_cache_coherency_bench
`default_nettype wire
